// *** dpce_pkg.sv ***
// Shared constants, opcodes and states of the potentiometer command engine
package dpce_pkg;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int VAL_W = 6;
  localparam int NUM_SETTINGS = 4;
  localparam int TAPS = 64;
  localparam int BYTE_BITS = 8;
  localparam int OPC_MSB = 7;
  localparam int OPC_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 2;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int ADDR_MSB = 3;
  localparam int ADDR_LSB = 0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SET = 4'hB;
  localparam logic [3:0] OP_WR_SET = 4'hC;
  localparam logic [3:0] OP_SET_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_WIPER_TO_SET = 4'hE;
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [1:0] DATA_PAD = 2'h0;
  localparam logic [5:0] WIPER_MAX = 6'h3F;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam logic [5:0] WIPER_RESET = 6'h00;
  localparam logic [5:0] SETTING_RESET = 6'h00;
  localparam logic [63:0] TAP_RESET = 64'h0000_0000_0000_0001;
  // Longest nonvolatile write time; count is an exact product, no rounding
  localparam int NV_WRITE_TIME_MS = 10;
  localparam int NV_WRITE_CYCLES_DEF = NV_WRITE_TIME_MS * CLK_FREQ_MHZ * 1000;
  // Wiper settle delay; no figure is given, so a plain default is used
  localparam int WIPER_SETTLE_NS = 400;
  localparam int WIPER_SETTLE_CYCLES = (WIPER_SETTLE_NS * CLK_FREQ_MHZ) / 1000;
  localparam logic [7:0] SETTLE_LOAD = 8'(WIPER_SETTLE_CYCLES);
  localparam logic [6:0] SYNC_IDLE = 7'h7F;

  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_ADDR,
    ST_INSTR,
    ST_WDATA,
    ST_RDATA,
    ST_STEP,
    ST_WAIT_STOP
  } dpce_state_t;
endpackage

// *** dpce_sync.sv ***
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/10ps
module dpce_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpce_sync_t;

  dpce_sync_t r_reg;
  dpce_sync_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= {INIT, INIT};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule // dpce_sync

// *** dpce_nvstore.sv ***
// Four stored settings with a timed nonvolatile write cycle
`timescale 1ns/10ps
module dpce_nvstore
  import dpce_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_req,
  input wire logic [1:0] wr_idx,
  input wire logic [VAL_W-1:0] wr_data,
  output logic [NUM_SETTINGS*VAL_W-1:0] settings,
  output logic busy
);
  localparam int CW = $clog2(NV_WRITE_CYCLES + 1);

  typedef struct packed {
    logic [NUM_SETTINGS*VAL_W-1:0] mem;
    logic busy;
    logic [CW-1:0] cnt;
    logic [1:0] idx;
    logic [VAL_W-1:0] data;
  } dpce_nv_t;

  dpce_nv_t r_reg;
  dpce_nv_t r_next;
  logic commit;
  logic [NUM_SETTINGS*VAL_W-1:0] mem_next;

  // Cell contents change only when the write cycle ends
  assign commit = r_reg.busy && (r_reg.cnt == CW'(1));

  for (genvar i = 0; i < NUM_SETTINGS; i++) begin : g_cell
    assign mem_next[i*VAL_W +: VAL_W] = (commit && r_reg.idx == 2'(i)) ?
        r_reg.data : r_reg.mem[i*VAL_W +: VAL_W];
  end

  always_comb begin
    r_next = r_reg;
    r_next.mem = mem_next;
    if (r_reg.busy) begin
      r_next.cnt = r_reg.cnt - CW'(1);
      r_next.busy = !commit;
    end else if (wr_req) begin
      r_next.busy = 1'b1;
      r_next.cnt = CW'(NV_WRITE_CYCLES);
      r_next.idx = wr_idx;
      r_next.data = wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign settings = r_reg.mem;
  assign busy = r_reg.busy;
endmodule // dpce_nvstore

// *** dpce_core.sv ***
// Two-wire command decoder, wiper counter and step logic of the potentiometer
`timescale 1ns/10ps
// Contract
// - Upper four instruction bits, MSB first, alone decide the operation.
// - Next two bits select one of four settings; low two bits sent zero.
// - Filler bits are ignored when decoding.
// - Transfers and step command finish after the instruction byte; master stops.
// - Setting-to-wiper load reaches the wiper output after the settle delay.
// - Wiper-to-setting transfer starts a timed nonvolatile write.
// - Register reads and writes use address, instruction and one data byte.
// - In step mode, each SCL high phase with SDA high moves wiper up one.
// - In step mode, each SCL high phase with SDA low moves wiper down one.
// - Opcode 1001 returns the wiper position in the data byte.
// - Opcode 1010 loads the wiper position from the master's data byte.
// - Opcode 1011 reads, 1100 writes the selected stored setting.
// - Opcode 1101 copies setting to wiper; 1110 copies wiper to setting.
// - Opcode 0010 enables step mode.
// - Six-bit wiper counter drives exactly one of sixty-four taps.
// - After power-up the wiper loads from stored setting zero.
// - Wiper position is volatile and lost at power-down.
// - Four six-bit stored settings, readable, writable, exchangeable with wiper.
// - Every setting change is a nonvolatile write finishing within 10 ms.
// - Data byte is two zeros then six value bits, MSB first.
// - Address byte is type code plus four address bits; all must match.
// - Device acknowledges address, instruction and following data byte.
// - Address is not acknowledged while a nonvolatile write runs.
// - Write-protect low blocks every nonvolatile write.
module dpce_core
  import dpce_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYCLES_DEF,
  // Device type code; value is arbitrary
  parameter logic [3:0] DEV_TYPE_ID = 4'hA
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [3:0] dev_addr_bits,
  input wire logic wp_n,
  output logic [TAPS-1:0] wiper_tap,
  output logic [VAL_W-1:0] wiper_value_bits,
  output logic nv_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  localparam int SETTLE_MAX = WIPER_SETTLE_CYCLES + 2;

  typedef struct packed {
    dpce_state_t state;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [3:0] op;
    logic [1:0] sel;
    logic step_up;
    logic sda_oe;
    logic sda_o;
    logic [VAL_W-1:0] wiper;
    logic [TAPS-1:0] tap;
    logic [VAL_W-1:0] wiper_out;
    logic [7:0] settle_cnt;
    logic settle_pend;
    logic nv_pend;
    logic [1:0] nv_idx;
    logic [VAL_W-1:0] nv_data;
    logic wr_req;
  } dpce_core_t;

  dpce_core_t r_reg;
  dpce_core_t r_next;
  logic [6:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_n_s;
  logic [3:0] addr_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic addr_match;
  logic op_valid;
  logic [NUM_SETTINGS*VAL_W-1:0] settings;
  logic [VAL_W-1:0] sel_setting;
  logic [VAL_W-1:0] power_up_setting_reg;
  logic busy;

  dpce_sync #(
    .W(7),
    .INIT(SYNC_IDLE)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({scl_in, sda_in, wp_n, dev_addr_bits}),
    .q(pins_s)
  );

  dpce_nvstore #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
  ) u_nv (
    .core_clk(core_clk),
    .rst(rst),
    .wr_req(r_reg.wr_req),
    .wr_idx(r_reg.nv_idx),
    .wr_data(r_reg.nv_data),
    .settings(settings),
    .busy(busy)
  );

  assign scl_s = pins_s[6];
  assign sda_s = pins_s[5];
  assign wp_n_s = pins_s[4];
  assign addr_s = pins_s[3:0];
  assign scl_rise = scl_s && !r_reg.scl_q;
  assign scl_fall = !scl_s && r_reg.scl_q;
  // Data may only move while SCL is low; an SDA edge with SCL high frames a command
  assign start_seen = scl_s && r_reg.scl_q && r_reg.sda_q && !sda_s;
  assign stop_seen = scl_s && r_reg.scl_q && !r_reg.sda_q && sda_s;
  assign addr_match = (r_reg.shreg[TYPE_MSB:TYPE_LSB] == DEV_TYPE_ID) &&
      (r_reg.shreg[ADDR_MSB:ADDR_LSB] == addr_s);
  // Only the opcode bits are looked at; select and filler bits never disqualify
  assign op_valid = r_reg.shreg[OPC_MSB:OPC_LSB] inside {OP_RD_WIPER, OP_WR_WIPER,
      OP_RD_SET, OP_WR_SET, OP_SET_TO_WIPER, OP_WIPER_TO_SET, OP_STEP};
  assign sel_setting = settings[VAL_W*r_reg.sel +: VAL_W];
  assign power_up_setting_reg = settings[VAL_W-1:0];

  always_comb begin
    r_next = r_reg;
    r_next.scl_q = scl_s;
    r_next.sda_q = sda_s;
    r_next.wr_req = 1'b0;
    r_next.sda_o = 1'b0;
    if (r_reg.state == ST_PWRUP) begin
      r_next.wiper = power_up_setting_reg;
      r_next.state = ST_IDLE;
    end else if (start_seen) begin
      r_next.state = ST_ADDR;
      r_next.bit_cnt = 4'h0;
      r_next.sda_oe = 1'b0;
      r_next.nv_pend = 1'b0;
    end else if (stop_seen) begin
      // The nonvolatile cycle begins only at the stop that ends the command
      r_next.wr_req = r_reg.nv_pend && wp_n_s;
      r_next.nv_pend = 1'b0;
      r_next.state = ST_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (r_reg.state == ST_STEP) begin
        r_next.step_up = sda_s;
      end else if (r_reg.bit_cnt < BIT_ACK) begin
        r_next.shreg = {r_reg.shreg[6:0], sda_s};
        r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
      end else if (r_reg.bit_cnt == BIT_ACK) begin
        r_next.bit_cnt = BIT_DONE;
      end
    end else if (scl_fall) begin
      // A step is applied when its high phase ends, so the phase carrying a stop never counts
      if (r_reg.state == ST_STEP) begin
        if (r_reg.step_up && r_reg.wiper != WIPER_MAX) begin
          r_next.wiper = 6'(r_reg.wiper + 6'h01);
        end else if (!r_reg.step_up && r_reg.wiper != WIPER_MIN) begin
          r_next.wiper = 6'(r_reg.wiper - 6'h01);
        end
      end else if (r_reg.bit_cnt == BIT_ACK) begin
        case (r_reg.state)
          ST_ADDR: begin
            if (addr_match && !busy) begin
              r_next.sda_oe = 1'b1;
            end else begin
              r_next.state = ST_IDLE;
            end
          end
          ST_INSTR: begin
            if (op_valid) begin
              r_next.sda_oe = 1'b1;
              r_next.op = r_reg.shreg[OPC_MSB:OPC_LSB];
              r_next.sel = r_reg.shreg[SEL_MSB:SEL_LSB];
            end else begin
              r_next.state = ST_IDLE;
            end
          end
          ST_WDATA: begin
            r_next.sda_oe = 1'b1;
            if (r_reg.op == OP_WR_WIPER) begin
              r_next.wiper = r_reg.shreg[VAL_W-1:0];
            end else begin
              r_next.nv_pend = 1'b1;
              r_next.nv_idx = r_reg.sel;
              r_next.nv_data = r_reg.shreg[VAL_W-1:0];
            end
          end
          ST_RDATA: begin
            r_next.sda_oe = 1'b0;
          end
          default: begin
            r_next.sda_oe = 1'b0;
          end
        endcase
      end else if (r_reg.bit_cnt == BIT_DONE) begin
        r_next.bit_cnt = 4'h0;
        r_next.sda_oe = 1'b0;
        case (r_reg.state)
          ST_ADDR: begin
            r_next.state = ST_INSTR;
          end
          ST_INSTR: begin
            case (r_reg.op)
              OP_RD_WIPER, OP_RD_SET: begin
                r_next.tx = {DATA_PAD, (r_reg.op == OP_RD_WIPER) ?
                    r_reg.wiper : sel_setting};
                r_next.sda_oe = 1'b1;
                r_next.state = ST_RDATA;
              end
              OP_WR_WIPER, OP_WR_SET: begin
                r_next.state = ST_WDATA;
              end
              OP_SET_TO_WIPER: begin
                r_next.wiper = sel_setting;
                r_next.state = ST_WAIT_STOP;
              end
              OP_WIPER_TO_SET: begin
                r_next.nv_pend = 1'b1;
                r_next.nv_idx = r_reg.sel;
                r_next.nv_data = r_reg.wiper;
                r_next.state = ST_WAIT_STOP;
              end
              OP_STEP: begin
                r_next.state = ST_STEP;
              end
              default: begin
                r_next.state = ST_IDLE;
              end
            endcase
          end
          default: begin
            r_next.state = ST_WAIT_STOP;
          end
        endcase
      end else if (r_reg.state == ST_RDATA) begin
        // Open drain: a zero bit is driven low, a one bit releases the line
        r_next.sda_oe = !r_reg.tx[6];
        r_next.tx = {r_reg.tx[6:0], 1'b0};
      end
    end
    if (r_reg.state == ST_RDATA && r_reg.bit_cnt == 4'h0 && scl_fall && r_reg.sda_oe == r_reg.tx[7]) begin
      r_next.sda_oe = !r_reg.tx[7];
    end
    // Any wiper change restarts the settle timer before the taps follow
    if (r_next.wiper != r_reg.wiper) begin
      r_next.settle_cnt = SETTLE_LOAD;
      r_next.settle_pend = 1'b1;
    end else if (r_reg.settle_pend) begin
      if (r_reg.settle_cnt <= 8'h01) begin
        r_next.settle_pend = 1'b0;
        r_next.tap = TAP_RESET << r_reg.wiper;
        r_next.wiper_out = r_reg.wiper;
      end else begin
        r_next.settle_cnt = 8'(r_reg.settle_cnt - 8'h01);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.tap <= TAP_RESET;
      r_reg.wiper <= WIPER_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_out = r_reg.sda_o;
  assign sda_oe = r_reg.sda_oe;
  assign wiper_tap = r_reg.tap;
  assign wiper_value_bits = r_reg.wiper_out;
  assign nv_busy = busy;

  property p_bad_opcode;
    r_reg.state == ST_INSTR && scl_fall && r_reg.bit_cnt == BIT_ACK && !op_valid
      |=> r_reg.state == ST_IDLE && !r_reg.sda_oe;
  endproperty
  a_bad_opcode: assert property (p_bad_opcode) else $error("undefined opcode acked");

  property p_busy_nack;
    r_reg.state == ST_ADDR && scl_fall && r_reg.bit_cnt == BIT_ACK && busy
      |=> !r_reg.sda_oe ##1 r_reg.state != ST_INSTR;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

  property p_wp_block;
    stop_seen && !wp_n_s |=> !r_reg.wr_req ##1 !busy || $past(busy, 2);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("write ran under protect");

  property p_step_up;
    r_reg.state == ST_STEP && scl_fall && r_reg.step_up && !stop_seen && !start_seen
      |=> r_reg.wiper == (($past(r_reg.wiper) == WIPER_MAX) ? WIPER_MAX :
          6'($past(r_reg.wiper) + 6'h01));
  endproperty
  a_step_up: assert property (p_step_up) else $error("up step wrong");

  property p_step_down;
    r_reg.state == ST_STEP && scl_fall && !r_reg.step_up && !stop_seen && !start_seen
      |=> r_reg.wiper == (($past(r_reg.wiper) == WIPER_MIN) ? WIPER_MIN :
          6'($past(r_reg.wiper) - 6'h01));
  endproperty
  a_step_down: assert property (p_step_down) else $error("down step wrong");

  property p_onehot_tap;
    $onehot(wiper_tap) && wiper_tap[wiper_value_bits];
  endproperty
  a_onehot_tap: assert property (p_onehot_tap) else $error("tap not one-hot");

  property p_settle;
    $changed(r_reg.wiper) |=> $stable(wiper_tap) [*2];
  endproperty
  a_settle: assert property (p_settle) else $error("wiper moved before settle");

  property p_settle_done;
    $changed(r_reg.wiper) ##1 $stable(r_reg.wiper) [*8]
      |-> ##[1:SETTLE_MAX] wiper_value_bits == r_reg.wiper || $changed(r_reg.wiper);
  endproperty
  a_settle_done: assert property (p_settle_done) else $error("wiper never settled");

  property p_power_up;
    r_reg.state == ST_PWRUP |=> r_reg.wiper == $past(power_up_setting_reg);
  endproperty
  a_power_up: assert property (p_power_up) else $error("power-up load missing");

  property p_nv_start;
    r_reg.wr_req |=> busy ##1 busy;
  endproperty
  a_nv_start: assert property (p_nv_start) else $error("write cycle not started");

  property p_read_pad;
    r_reg.state == ST_INSTR && scl_fall && r_reg.bit_cnt == BIT_DONE &&
      (r_reg.op == OP_RD_WIPER || r_reg.op == OP_RD_SET) |=> r_reg.tx[7:6] == DATA_PAD;
  endproperty
  a_read_pad: assert property (p_read_pad) else $error("read byte pad bits set");

  c_step: cover property (r_reg.state == ST_STEP ##[1:1000] stop_seen);
  c_nv_write: cover property (r_reg.wr_req);
  c_read: cover property (r_reg.state == ST_RDATA ##[1:1000] r_reg.state == ST_WAIT_STOP);
  c_wiper_write: cover property (r_reg.state == ST_WDATA && r_reg.op == OP_WR_WIPER &&
      scl_fall && r_reg.bit_cnt == BIT_ACK);
endmodule // dpce_core

// *** dpce_core_fix_note_unused.sv ***
// Holds no logic; nothing in this file belongs to the block

// *** dpce_master.sv ***
// Two-wire bus master model that drives the potentiometer's serial pins
`timescale 1ns/10ps
module dpce_master (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // A released line reads high through the pull-up
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One SCL period of 160 ns; SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    w(7);
    scl <= 1'b1;
    w(5);
    r = sda;
    w(5);
    scl <= 1'b0;
    w(3);
  endtask

  task automatic start();
    sda_m <= 1'b1;
    w(5);
    scl <= 1'b1;
    w(10);
    sda_m <= 1'b0;
    w(10);
    scl <= 1'b0;
    w(3);
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    w(5);
    scl <= 1'b1;
    w(10);
    sda_m <= 1'b1;
    w(10);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic rd_byte(output logic [7:0] b, input logic master_ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(!master_ack, r);
  endtask
endmodule // dpce_master

// *** tb_top.sv ***
// Self-checking bench for the potentiometer command engine
`timescale 1ns/10ps
module tb_top;
  import dpce_pkg::*;
  localparam logic [7:0] ADDR = 8'hA6;
  logic core_clk, rst, wp_n, scl, sda_m, sda, sda_out, sda_oe, nv_busy, a1, a2, a3;
  logic [3:0] dev_addr_bits;
  logic [TAPS-1:0] wiper_tap;
  logic [VAL_W-1:0] wiper_value_bits;
  logic [7:0] rd;
  int mismatches = 0;
  int compares = 0;

  assign sda = sda_oe ? 1'b0 : sda_m;

  dpce_core #(.NV_WRITE_CYCLES(600)) dut_u (.core_clk(core_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .dev_addr_bits(dev_addr_bits),
    .wp_n(wp_n), .wiper_tap(wiper_tap), .wiper_value_bits(wiper_value_bits),
    .nv_busy(nv_busy));
  dpce_master master_u (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_m(sda_m));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Kind 0 ends after the instruction, 1 writes a data byte, 2 reads one
  task automatic cmd(input logic [7:0] ad, input logic [7:0] ins, input int kind,
      input logic [7:0] wd);
    a2 = 1'b0;
    a3 = 1'b0;
    rd = 8'h00;
    master_u.start();
    master_u.wr_byte(ad, a1);
    if (a1) master_u.wr_byte(ins, a2);
    if (a2 && kind == 1) master_u.wr_byte(wd, a3);
    if (a2 && kind == 2) master_u.rd_byte(rd, 1'b1);
    master_u.stop();
  endtask

  task automatic poll();
    int n;
    n = 0;
    a1 = 1'b0;
    while (a1 !== 1'b1 && n < 20) begin
      master_u.start();
      master_u.wr_byte(ADDR, a1);
      master_u.stop();
      n++;
    end
    check(a1, 1'b1);
    if (a1 !== 1'b1) results();
  endtask

  task automatic wiper_is(input logic [5:0] v);
    w(60);
    check(wiper_value_bits, v);
    check(wiper_tap, 64'h0000_0000_0000_0001 << v);
    check(sda_out, 1'b0);
  endtask

  task automatic t_wiper();
    cmd(ADDR, 8'hA3, 1, 8'hEA);
    check({a1, a2, a3}, 3'h7);
    check(wiper_value_bits, 6'h00);
    wiper_is(6'h2A);
    cmd(ADDR, 8'h90, 2, 8'h00);
    check(rd, 8'h2A);
  endtask

  task automatic t_settings();
    for (int i = 0; i < 4; i++) begin
      cmd(ADDR, {OP_WR_SET, 2'(i), 2'h0}, 1, 8'(8'h10 + i));
      check(nv_busy, 1'b1);
      master_u.start();
      master_u.wr_byte(ADDR, a1);
      master_u.stop();
      check(a1, 1'b0);
      poll();
    end
    for (int i = 3; i >= 0; i--) begin
      cmd(ADDR, {OP_RD_SET, 2'(i), 2'h0}, 2, 8'h00);
      check(rd, 8'(8'h10 + i));
    end
  endtask

  task automatic t_xfer();
    cmd(ADDR, {OP_SET_TO_WIPER, 2'h3, 2'h0}, 0, 8'h00);
    check({a1, a2}, 2'h3);
    wiper_is(6'h13);
    cmd(ADDR, {OP_WIPER_TO_SET, 2'h1, 2'h0}, 0, 8'h00);
    check(nv_busy, 1'b1);
    poll();
    cmd(ADDR, {OP_RD_SET, 2'h1, 2'h0}, 2, 8'h00);
    check(rd, 8'h13);
  endtask

  // Steps are taken from the low bit of pat upward
  task automatic t_step(input logic [5:0] st, input logic [4:0] pat, input int n,
      input logic [5:0] exp);
    logic r;
    cmd(ADDR, {OP_WR_WIPER, 4'h0}, 1, {2'h0, st});
    master_u.start();
    master_u.wr_byte(ADDR, a1);
    master_u.wr_byte({OP_STEP, 4'h0}, a2);
    check(a2, 1'b1);
    for (int i = 0; i < n; i++) begin
      master_u.bit_io(pat[i], r);
    end
    master_u.stop();
    wiper_is(exp);
  endtask

  task automatic t_refuse();
    cmd(ADDR, 8'h00, 1, 8'h3F);
    check(a2, 1'b0);
    cmd(ADDR, 8'hF0, 1, 8'h3F);
    check(a2, 1'b0);
    cmd(ADDR, 8'h30, 1, 8'h3F);
    check(a2, 1'b0);
    cmd(8'hA4, 8'hA0, 1, 8'h3F);
    check(a1, 1'b0);
    cmd(8'h36, 8'hA0, 1, 8'h3F);
    check(a1, 1'b0);
    wiper_is(6'h01);
  endtask

  task automatic t_protect();
    wp_n <= 1'b0;
    w(5);
    cmd(ADDR, {OP_WR_SET, 4'h0}, 1, 8'h3F);
    check(a3, 1'b1);
    w(3);
    check(nv_busy, 1'b0);
    cmd(ADDR, {OP_WIPER_TO_SET, 4'h0}, 0, 8'h00);
    w(3);
    check(nv_busy, 1'b0);
    wp_n <= 1'b1;
    cmd(ADDR, {OP_RD_SET, 4'h0}, 2, 8'h00);
    check(rd, 8'h10);
  endtask

  initial begin
    #800000;
    mismatches++;
    results();
  end

  initial begin
    rst <= 1'b1;
    wp_n <= 1'b1;
    dev_addr_bits <= 4'h6;
    w(16);
    rst <= 1'b0;
    wiper_is(6'h00);
    t_wiper();
    t_settings();
    t_xfer();
    t_step(6'h3E, 5'b00111, 5, 6'h3D);
    t_step(6'h01, 5'b01000, 4, 6'h01);
    t_refuse();
    t_protect();
    rst <= 1'b1;
    w(16);
    rst <= 1'b0;
    wiper_is(6'h00);
    results();
  end
endmodule // tb_top
